// file: logic/voice_sample_tdm_link.sv
/*
  voice sample time-division link toward an external codec, with the host
  memory and user register ports, frame exchange and a tone generator.
  assumes clk_link is a free running clock at twice the master clock rate,
  and that the codec is strapped as a serial slave.
*/
`include "voice_tdm_defines.svh"
module voice_sample_tdm_link (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_link,
  input  wire logic        memWrite,
  input  wire logic        memRead,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWrData,
  output logic      [15:0] memRdData,
  output logic             memRdValid,
  input  wire logic        userRegWrite,
  input  wire logic [7:0]  userRegNum,
  input  wire logic [15:0] userRegData,
  input  wire logic        toneStart,
  input  wire logic [3:0]  toneDigit,
  output logic             toneBusy,
  input  wire logic [15:0] lineToCodec,
  input  wire logic        lineToCodecValid,
  output logic      [15:0] codecToLine,
  output logic             codecToLineValid,
  output logic             codecMclk,
  output logic             frameSyncPulse,
  output logic             codecDataIn,
  input  wire logic        codecSerialOut
);

  //****************************************************************
  // system domain
  //****************************************************************
  logic [15:0]             enableReg, next_enableReg;
  logic [15:0]             routingReg, next_routingReg;
  logic                    ctrlPend, next_ctrlPend;
  logic [15:0]             ctrlWord, next_ctrlWord;
  logic [15:0]             txPend, next_txPend;
  voice_tdm_pkg::txFrame_s txHold, next_txHold;
  logic                    ackTgl, next_ackTgl;
  logic [2:0]              reqSync, rxSync;
  logic [15:0]             next_memRdData, next_codecToLine;
  logic                    next_memRdValid, next_codecToLineValid;
  voice_tdm_pkg::toneState_e toneState, next_toneState;
  logic [9:0]              toneFrames, next_toneFrames;
  logic [15:0]             rowPh, next_rowPh, colPh, next_colPh;
  logic [15:0]             rowInc, next_rowInc, colInc, next_colInc;
  logic                    next_toneBusy;
  logic [15:0]             rxHold;
  logic                    reqTgl, rxTgl;
  logic                    linear, reqEdge, rxEdge;
  logic [15:0]             toneSample, rowInc0, colInc0;

  assign linear = enableReg[`ENABLE_BIT] && (routingReg == `ROUTING_LINEAR);
  assign reqEdge = reqSync[2] ^ reqSync[1];
  assign rxEdge = rxSync[2] ^ rxSync[1];
  // sum of two square waves, one per tone group
  assign toneSample = (rowPh[15] ? `TONE_AMP : -`TONE_AMP)
                    + (colPh[15] ? `TONE_AMP : -`TONE_AMP);

  // digit to row and column phase steps, E and F are star and hash
  always_comb
  begin
    unique case (toneDigit)
      4'h1, 4'h2, 4'h3, 4'hA: rowInc0 = `ROW0_INC;
      4'h4, 4'h5, 4'h6, 4'hB: rowInc0 = `ROW1_INC;
      4'h7, 4'h8, 4'h9, 4'hC: rowInc0 = `ROW2_INC;
      4'hE, 4'h0, 4'hF, 4'hD: rowInc0 = `ROW3_INC;
    endcase
    unique case (toneDigit)
      4'h1, 4'h4, 4'h7, 4'hE: colInc0 = `COL0_INC;
      4'h2, 4'h5, 4'h8, 4'h0: colInc0 = `COL1_INC;
      4'h3, 4'h6, 4'h9, 4'hF: colInc0 = `COL2_INC;
      4'hA, 4'hB, 4'hC, 4'hD: colInc0 = `COL3_INC;
    endcase
  end

  // host ports, frame hand-over and tone sequencing
  always_comb
  begin
    next_enableReg = enableReg;
    next_routingReg = routingReg;
    next_ctrlPend = ctrlPend;
    next_ctrlWord = ctrlWord;
    next_txPend = txPend;
    next_txHold = txHold;
    next_ackTgl = ackTgl;
    next_memRdData = memRdData;
    next_memRdValid = 1'b0;
    next_codecToLine = codecToLine;
    next_codecToLineValid = 1'b0;
    next_toneState = toneState;
    next_toneFrames = toneFrames;
    next_rowPh = rowPh;
    next_colPh = colPh;
    next_rowInc = rowInc;
    next_colInc = colInc;
    if (memWrite && memAddr == `ENABLE_ADDR)
      next_enableReg = memWrData;
    if (userRegWrite && userRegNum == `ROUTING_NUM)
      next_routingReg = userRegData;
    if (memRead)
    begin
      next_memRdValid = 1'b1;
      next_memRdData = (memAddr == `ENABLE_ADDR) ? enableReg : `READ_UNMAPPED;
    end
    if (lineToCodecValid)
      next_txPend = lineToCodec;
    // frame request from the link: hand over sample and control word
    if (reqEdge)
    begin
      next_txHold.sample = linear ? txPend : '0;
      next_txHold.ctrlValid = ctrlPend;
      next_txHold.ctrlWord = ctrlWord;
      next_ctrlPend = 1'b0;
      next_ackTgl = ~ackTgl;
    end
    // a write in the hand-over cycle wins over the clear
    if (memWrite && memAddr == `CTRL_PORT_ADDR)
    begin
      next_ctrlPend = 1'b1;
      next_ctrlWord = memWrData;
    end
    // one received sample per frame toward the line path
    if (rxEdge)
    begin
      next_codecToLineValid = 1'b1;
      if (toneState == voice_tdm_pkg::TONE_PLAY)
        next_codecToLine = toneSample;
      else
        next_codecToLine = linear ? rxHold : '0;
    end
    unique case (toneState)
      voice_tdm_pkg::TONE_IDLE:
        if (toneStart)
        begin
          next_toneState = voice_tdm_pkg::TONE_PLAY;
          next_toneFrames = `TONE_FRAMES;
          next_rowInc = rowInc0;
          next_colInc = colInc0;
          next_rowPh = '0;
          next_colPh = '0;
        end
      voice_tdm_pkg::TONE_PLAY:
        if (rxEdge)
        begin
          next_rowPh = rowPh + rowInc;
          next_colPh = colPh + colInc;
          next_toneFrames = toneFrames - 10'h001;
          if (toneFrames == `TONE_LAST)
            next_toneState = voice_tdm_pkg::TONE_IDLE;
        end
    endcase
    next_toneBusy = (next_toneState == voice_tdm_pkg::TONE_PLAY);
  end

  // system registers, all settings back to defaults on reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      enableReg <= `ENABLE_RESET;
      routingReg <= `ROUTING_RESET;
      ctrlPend <= 1'b0;
      ctrlWord <= '0;
      txPend <= '0;
      txHold <= '0;
      ackTgl <= 1'b0;
      reqSync <= '0;
      rxSync <= '0;
      memRdData <= '0;
      memRdValid <= 1'b0;
      codecToLine <= '0;
      codecToLineValid <= 1'b0;
      toneState <= voice_tdm_pkg::TONE_IDLE;
      toneFrames <= '0;
      rowPh <= '0;
      colPh <= '0;
      rowInc <= '0;
      colInc <= '0;
      toneBusy <= 1'b0;
    end
    else
    begin
      enableReg <= next_enableReg;
      routingReg <= next_routingReg;
      ctrlPend <= next_ctrlPend;
      ctrlWord <= next_ctrlWord;
      txPend <= next_txPend;
      txHold <= next_txHold;
      ackTgl <= next_ackTgl;
      reqSync <= {reqSync[1:0], reqTgl}; // toggle crossing
      rxSync <= {rxSync[1:0], rxTgl};
      memRdData <= next_memRdData;
      memRdValid <= next_memRdValid;
      codecToLine <= next_codecToLine;
      codecToLineValid <= next_codecToLineValid;
      toneState <= next_toneState;
      toneFrames <= next_toneFrames;
      rowPh <= next_rowPh;
      colPh <= next_colPh;
      rowInc <= next_rowInc;
      colInc <= next_colInc;
      toneBusy <= next_toneBusy;
    end
  end

  //****************************************************************
  // link domain
  //****************************************************************
  logic [1:0]              rstLinkSync, enSync, sdoSync;
  logic [2:0]              ackSync;
  logic                    phase, next_phase, next_codecMclk;
  logic [7:0]              bitCnt, next_bitCnt;
  logic [31:0]             txShift, next_txShift;
  logic [15:0]             rxShift, next_rxShift, next_rxHold;
  logic                    next_rxTgl, next_reqTgl;
  logic                    next_frameSyncPulse, next_codecDataIn;
  voice_tdm_pkg::txFrame_s txNext, next_txNext;
  logic                    rstLink, linkActive;
  logic [7:0]              bitInc;

  assign rstLink = rstLinkSync[1];
  assign linkActive = enSync[1];
  assign bitInc = bitCnt + 8'h01;

  // master clock, bit counter, frame sync and serial shifting
  always_comb
  begin
    next_phase = ~phase;
    next_codecMclk = phase;
    next_bitCnt = bitCnt;
    next_txShift = txShift;
    next_rxShift = rxShift;
    next_rxHold = rxHold;
    next_rxTgl = rxTgl;
    next_reqTgl = reqTgl;
    next_frameSyncPulse = frameSyncPulse;
    next_codecDataIn = codecDataIn;
    next_txNext = txNext;
    if (ackSync[2] ^ ackSync[1])
      next_txNext = txHold; // stable until the next request
    if (!linkActive)
    begin
      next_phase = 1'b1;
      next_codecMclk = 1'b0;
      next_bitCnt = `IDLE_BITCNT;
      next_frameSyncPulse = 1'b0;
      next_codecDataIn = 1'b0;
    end
    else if (phase)
    begin
      next_bitCnt = (bitCnt == `FRAME_LAST) ? `BIT_FIRST : bitInc;
      next_frameSyncPulse = (next_bitCnt == `BIT_FIRST);
      if (next_bitCnt == `BIT_FIRST)
        next_txShift = {txNext.sample,
                        txNext.ctrlValid ? txNext.ctrlWord : 16'h0000};
      else
        next_txShift = {txShift[30:0], 1'b0};
      next_codecDataIn = (next_bitCnt < `TX_BITS) && next_txShift[31];
      if (next_bitCnt >= `RX_FIRST && next_bitCnt <= `RX_LAST)
        next_rxShift = {rxShift[14:0], sdoSync[1]};
      if (next_bitCnt == `RX_LAST)
      begin
        next_rxHold = {rxShift[14:0], sdoSync[1]};
        next_rxTgl = ~rxTgl;
      end
      if (next_bitCnt == `FRAME_LAST)
        next_reqTgl = ~reqTgl;
    end
  end

  // link registers; reset released in step with the link clock
  always_ff @(posedge clk_link or posedge rst)
  begin
    if (rst)
    begin
      rstLinkSync <= 2'b11;
      enSync <= '0;
      sdoSync <= '0;
      ackSync <= '0;
    end
    else
    begin
      rstLinkSync <= {rstLinkSync[0], 1'b0};
      enSync <= {enSync[0], enableReg[`ENABLE_BIT]};
      sdoSync <= {sdoSync[0], codecSerialOut};
      ackSync <= {ackSync[1:0], ackTgl};
    end
  end

  always_ff @(posedge clk_link or posedge rstLink)
  begin
    if (rstLink)
    begin
      phase <= 1'b1;
      codecMclk <= 1'b0;
      bitCnt <= `IDLE_BITCNT;
      txShift <= '0;
      rxShift <= '0;
      rxHold <= '0;
      rxTgl <= 1'b0;
      reqTgl <= 1'b0;
      frameSyncPulse <= 1'b0;
      codecDataIn <= 1'b0;
      txNext <= '0;
    end
    else
    begin
      phase <= next_phase;
      codecMclk <= next_codecMclk;
      bitCnt <= next_bitCnt;
      txShift <= next_txShift;
      rxShift <= next_rxShift;
      rxHold <= next_rxHold;
      rxTgl <= next_rxTgl;
      reqTgl <= next_reqTgl;
      frameSyncPulse <= next_frameSyncPulse;
      codecDataIn <= next_codecDataIn;
      txNext <= next_txNext;
    end
  end

  //****************************************************************
  // checks
  //****************************************************************
  logic [9:0] syncGap;
  always_ff @(posedge clk_link or posedge rstLink)
  begin
    if (rstLink)
      syncGap <= '0;
    else
      syncGap <= $rose(frameSyncPulse) ? 10'h001 : syncGap + 10'h001;
  end

  sequence s_syncPulse;
    frameSyncPulse [*2] ##1 !frameSyncPulse;
  endsequence
  property p_syncShape;
    @(posedge clk_link) disable iff (rstLink)
      $rose(frameSyncPulse) |-> s_syncPulse;
  endproperty
  a_syncShape: assert property (p_syncShape) else $error("sync width");
  property p_frameLen;
    @(posedge clk_link) disable iff (rstLink)
      $rose(frameSyncPulse) && $past(linkActive, 3) && syncGap != 10'h000
      |-> syncGap == 10'h200;
  endproperty
  a_frameLen: assert property (p_frameLen) else $error("frame length");
  property p_mclkRuns;
    @(posedge clk_link) disable iff (rstLink)
      linkActive && $past(linkActive, 2) |-> codecMclk != $past(codecMclk);
  endproperty
  a_mclkRuns: assert property (p_mclkRuns) else $error("mclk stuck");
  property p_idleQuiet;
    @(posedge clk_link) disable iff (rstLink)
      !linkActive ##1 !linkActive |-> !codecMclk && !frameSyncPulse;
  endproperty
  a_idleQuiet: assert property (p_idleQuiet) else $error("idle active");
  property p_msbFirst;
    @(posedge clk_link) disable iff (rstLink)
      $rose(frameSyncPulse) |-> codecDataIn == $past(txNext.sample[15]);
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("msb order");
  property p_rxPass;
    @(posedge clk_sys) disable iff (rst)
      rxEdge && linear && toneState == voice_tdm_pkg::TONE_IDLE
      |=> codecToLineValid && codecToLine == $past(rxHold);
  endproperty
  a_rxPass: assert property (p_rxPass) else $error("rx routing");
  property p_ctrlQueue;
    @(posedge clk_sys) disable iff (rst)
      memWrite && memAddr == `CTRL_PORT_ADDR
      |=> ctrlPend && ctrlWord == $past(memWrData);
  endproperty
  a_ctrlQueue: assert property (p_ctrlQueue) else $error("ctrl lost");
  property p_ctrlFwd;
    @(posedge clk_sys) disable iff (rst)
      reqEdge && ctrlPend && !memWrite
      |=> txHold.ctrlValid && txHold.ctrlWord == $past(ctrlWord) && !ctrlPend;
  endproperty
  a_ctrlFwd: assert property (p_ctrlFwd) else $error("ctrl forward");
  property p_toneStart;
    @(posedge clk_sys) disable iff (rst)
      toneStart && toneState == voice_tdm_pkg::TONE_IDLE |=> toneBusy;
  endproperty
  a_toneStart: assert property (p_toneStart) else $error("no tone");

endmodule : voice_sample_tdm_link

// file: logic/voice_tdm_defines.svh
/*
  constants for the voice sample time-division link: memory locations,
  field positions, reset values, frame timing and tone generator figures.
  assumes it is included by its bare name from the design and the bench.
*/
`ifndef VOICE_TDM_DEFINES_SVH
`define VOICE_TDM_DEFINES_SVH

// memory locations reached by the memory write command, and the enable location by the read command too
`define ENABLE_ADDR      16'h0059
`define CTRL_PORT_ADDR   16'h004B
// register number reached by the user register write command
`define ROUTING_NUM      8'h71
`define ROUTING_LINEAR   16'h0011
`define ENABLE_BIT       0
`define ENABLE_RESET     16'h0000
`define ROUTING_RESET    16'h0000
`define READ_UNMAPPED    16'h0000

// link timing: link clock is twice the codec master clock
`define LINK_CLK_KHZ     4096
`define MCLK_KHZ         2048
`define FRAME_KHZ        8
`define FRAME_LAST       8'((`MCLK_KHZ / `FRAME_KHZ) - 1)
`define BIT_FIRST        8'h00
// codec bit k reaches the counter at bit k+2 through the input sync flops,
// so the capture window is shifted two bits to take bits 0..15
`define RX_FIRST         8'h02
`define RX_LAST          8'h11
`define TX_BITS          8'h20
`define IDLE_BITCNT      8'hFF

// tone generator: duration in frames, amplitude, phase steps per frame
`define TONE_MS          100
`define TONE_FRAMES      10'(`TONE_MS * `FRAME_KHZ)
`define TONE_LAST        10'h001
`define TONE_AMP         16'h1000
`define ROW0_INC         16'h164E
`define ROW1_INC         16'h18A4
`define ROW2_INC         16'h1B44
`define ROW3_INC         16'h1E1D
`define COL0_INC         16'h26B0
`define COL1_INC         16'h2AC1
`define COL2_INC         16'h2F44
`define COL3_INC         16'h3442

`endif

// file: logic/voice_tdm_pkg.sv
/*
  types shared by the voice sample time-division link.
  assumes voice_tdm_defines.svh is on the include path.
*/
package voice_tdm_pkg;

  // one frame's worth of traffic toward the codec
  typedef struct packed {
    logic        ctrlValid;
    logic [15:0] ctrlWord;
    logic [15:0] sample;
  } txFrame_s;

  typedef enum logic {TONE_IDLE, TONE_PLAY} toneState_e;

endpackage : voice_tdm_pkg

// file: bench/codec_model.sv
/*
  behavioural voice codec in slave serial mode, plus link timing probes.
  assumes master clock, frame sync and serial data come from the link block.
*/
module codec_model
(
  input  wire logic        clk_link,
  input  wire logic        codecMclk,
  input  wire logic        frameSyncPulse,
  input  wire logic        codecDataIn,
  input  wire logic [15:0] txSample,
  output logic             codecSerialOut,
  output logic      [15:0] rxSample,
  output logic      [15:0] rxCtrl,
  output logic             frameDone,
  output logic      [15:0] framePeriod,
  output logic      [15:0] syncWidth,
  output logic      [15:0] mclkPeriod
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] shiftIn;
  logic [5:0]  bitIdx;
  logic        started;
  logic        mclkPrev;
  logic        syncPrev;
  logic [15:0] cyc;
  logic [15:0] mc;
  logic [15:0] sw;

  // ****************************************
  // codec serial slave
  // ****************************************
  initial
  begin
    codecSerialOut = 1'b0;
    bitIdx         = 6'h20;
    started        = 1'b0;
    frameDone      = 1'b0;
    {cyc, mc, sw, mclkPrev, syncPrev} = '0;
  end

  // codec takes all timing from the master clock and frame sync; it works
  // on the falling edge, mid-bit, where sync and data have settled
  always @(negedge codecMclk)
  begin
    if (frameSyncPulse)
    begin
      rxSample       <= shiftIn[31:16];
      rxCtrl         <= shiftIn[15:0];
      frameDone      <= started;
      started        <= 1'b1;
      shiftIn        <= {31'h0, codecDataIn};
      bitIdx         <= 6'h01;
      codecSerialOut <= txSample[15];
    end
    else
    begin
      frameDone <= 1'b0;
      if (bitIdx < 6'h20)
      begin
        shiftIn <= {shiftIn[30:0], codecDataIn};
        bitIdx  <= bitIdx + 6'h01;
      end
      // one bit per bit period; past the sample the released output
      // falls to the strap pull-down level
      codecSerialOut <= (bitIdx < 6'h10) ?
                        txSample[4'(6'h0F - bitIdx)] : 1'b0;
    end
  end

  // measures clock period, frame length and sync width in link cycles
  always @(posedge clk_link)
  begin
    mclkPrev <= codecMclk;
    syncPrev <= frameSyncPulse;
    mc       <= mc + 16'h0001;
    cyc      <= cyc + 16'h0001;
    sw       <= frameSyncPulse ? sw + 16'h0001 : 16'h0000;
    if (codecMclk && !mclkPrev)
    begin
      mclkPeriod <= mc + 16'h0001;
      mc         <= 16'h0000;
    end
    if (frameSyncPulse && !syncPrev)
    begin
      framePeriod <= cyc + 16'h0001;
      cyc         <= 16'h0000;
    end
    if (!frameSyncPulse && syncPrev)
      syncWidth <= sw;
  end
endmodule : codec_model

// file: bench/tb_top.sv
/*
  self-checking bench for the voice sample link with a codec model.
  assumes the defines header is on the include path.
*/
`include "voice_tdm_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        clk_link;
  logic        rst = 1'b1;
  logic        memWrite, memRead, userRegWrite, toneStart;
  logic        lineToCodecValid, memRdValid, toneBusy, codecToLineValid;
  logic        codecMclk, frameSyncPulse, codecDataIn, codecSerialOut;
  logic        frameDone;
  logic [3:0]  toneDigit;
  logic [7:0]  userRegNum;
  logic [15:0] memAddr, memWrData, memRdData, userRegData, lineToCodec;
  logic [15:0] codecToLine, txSample, rxSample, rxCtrl, en, lastCtrl;
  logic [15:0] framePeriod, syncWidth, mclkPeriod, smp, lin;
  logic [15:0] rdQ[$];
  logic [15:0] lineQ[$];
  int          n_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          nCtrl;
  int          seed;

  always #2 clk_sys = ~clk_sys;
  initial
  begin
    clk_link = 1'b0;
    #37.3;
    forever #80 clk_link = ~clk_link;
  end

  voice_sample_tdm_link dut (.clk_sys(clk_sys), .rst(rst),
    .clk_link(clk_link), .memWrite(memWrite), .memRead(memRead),
    .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
    .memRdValid(memRdValid), .userRegWrite(userRegWrite),
    .userRegNum(userRegNum), .userRegData(userRegData),
    .toneStart(toneStart), .toneDigit(toneDigit), .toneBusy(toneBusy),
    .lineToCodec(lineToCodec), .lineToCodecValid(lineToCodecValid),
    .codecToLine(codecToLine), .codecToLineValid(codecToLineValid),
    .codecMclk(codecMclk), .frameSyncPulse(frameSyncPulse),
    .codecDataIn(codecDataIn), .codecSerialOut(codecSerialOut));

  codec_model codec (.clk_link(clk_link), .codecMclk(codecMclk),
    .frameSyncPulse(frameSyncPulse), .codecDataIn(codecDataIn),
    .txSample(txSample), .codecSerialOut(codecSerialOut),
    .rxSample(rxSample), .rxCtrl(rxCtrl), .frameDone(frameDone),
    .framePeriod(framePeriod), .syncWidth(syncWidth),
    .mclkPeriod(mclkPeriod));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // reset spans two link edges so the link side sees it too
  task automatic reset_dut;
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    repeat (2) @(posedge clk_link);
    @(posedge clk_sys);
    rst <= 1'b0;
  endtask : reset_dut

  task automatic mem_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    memWrite  <= 1'b1;
    memAddr   <= a;
    memWrData <= d;
    @(posedge clk_sys);
    memWrite  <= 1'b0;
  endtask : mem_wr

  // the expected answer is queued for the read monitor
  task automatic mem_rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    memRead <= 1'b1;
    memAddr <= a;
    rdQ.push_back(e);
    @(posedge clk_sys);
    memRead <= 1'b0;
  endtask : mem_rd

  task automatic user_wr(input logic [7:0] n, input logic [15:0] d);
    @(posedge clk_sys);
    userRegWrite <= 1'b1;
    userRegNum   <= n;
    userRegData  <= d;
    @(posedge clk_sys);
    userRegWrite <= 1'b0;
  endtask : user_wr

  // ****************************************
  // monitors and timeout
  // ****************************************
  always @(posedge clk_sys)
  begin
    if (memRdValid === 1'b1 && rdQ.size() > 0)
      check(memRdData, rdQ.pop_front());
    if (codecToLineValid === 1'b1 && lineQ.size() > 0)
      check(codecToLine, lineQ.pop_front());
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      n_errors++;
      complete_run();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {memWrite, memRead, userRegWrite, toneStart, lineToCodecValid} = '0;
    {memAddr, memWrData, userRegData, lineToCodec} = '0;
    {toneDigit, userRegNum, txSample} = '0;
    seed = $urandom(32'h25CE8E79);
    reset_dut();
    mem_rd(`ENABLE_ADDR, `ENABLE_RESET);
    mem_rd(`CTRL_PORT_ADDR, `READ_UNMAPPED);
    mem_rd(16'h0100 | 16'($urandom_range(255)), `READ_UNMAPPED);
    repeat (20) @(posedge clk_link) check({15'h0, codecMclk}, 16'h0000);
    user_wr(`ROUTING_NUM + 8'h01, 16'h0000);
    user_wr(`ROUTING_NUM, `ROUTING_LINEAR);
    smp = 16'($urandom);
    lin = 16'($urandom);
    @(posedge clk_sys);
    txSample         <= smp;
    lineToCodec      <= lin;
    lineToCodecValid <= 1'b1;
    @(posedge clk_sys);
    lineToCodecValid <= 1'b0;
    // second word overwrites the first while still pending
    mem_wr(`CTRL_PORT_ADDR, 16'h011C);
    mem_wr(`CTRL_PORT_ADDR, 16'h055A);
    mem_rd(`ENABLE_ADDR, `ENABLE_RESET);
    en = (16'($urandom) & 16'hFFFE) | 16'h0001;
    mem_wr(`ENABLE_ADDR, en);
    mem_rd(`ENABLE_ADDR, en);
    nCtrl = 0;
    lastCtrl = 16'h0000;
    for (int f = 0; f < 4; f++)
    begin
      @(posedge frameDone);
      #1;
      if (rxCtrl !== 16'h0000)
      begin
        nCtrl++;
        lastCtrl = rxCtrl;
      end
      if (f == 1)
        lineQ.push_back(smp);
    end
    check(lastCtrl, 16'h055A);
    check(16'(nCtrl), 16'h0001);
    check(rxSample, lin);
    check(16'(lineQ.size()), 16'h0000);
    check(framePeriod, 16'h0200);
    check(syncWidth, 16'h0002);
    check(mclkPeriod, 16'h0002);
    // first digit starts a tone, later ones arrive while busy
    for (int d = 0; d < 16; d++)
    begin
      @(posedge clk_sys);
      toneStart <= 1'b1;
      toneDigit <= 4'(d);
      @(posedge clk_sys);
      toneStart <= 1'b0;
      @(posedge clk_sys);
      check({15'h0, toneBusy}, 16'h0001);
    end
    reset_dut();
    check({15'h0, toneBusy}, 16'h0000);
    mem_rd(`ENABLE_ADDR, `ENABLE_RESET);
    repeat (20) @(posedge clk_link) check({15'h0, frameSyncPulse}, 16'h0000);
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule : tb_top
